// *** logic/ccg_pkg.sv ***
// Package of constants and types for the CPU clock generator control
// ============================================================
// Overview of operation
// - Reset clears both select registers to zero
// - Four main-clock CPU rates from speed field
// - Sub clock selected: CPU runs at sub/4
// - STOP only on main clock; HALT always
// - Oscillator-stop bit acts only on sub clock
// - STOP sets bit 3, HALT sets bit 2
// - Standby release clears both standby bits
// - Nibble write updates speed field, standby zero
// - STOP and HALT ignore bank enable flag
// - Bits 0 and 3 change by bit access
// - Oscillator-stop bit grounds main oscillator input
// - Divided clocks to peripherals, sub to watch
// - Old clock persists for switching delay
package ccg_pkg;

    // ============================================================
    // Register fields
    localparam int SPD_LO      = 0;
    localparam int SPD_HI      = 1;
    localparam int HALT_BIT    = 2;
    localparam int STOP_BIT    = 3;
    localparam int SRC_BIT     = 0;
    localparam int OSCOFF_BIT  = 3;
    localparam logic [3:0] REG_RST = 4'h0;

    // ============================================================
    // Speed codes, main-clock divide ratios and the sub-clock ratio
    localparam logic [1:0] SPD_64 = 2'h0;
    localparam logic [1:0] SPD_16 = 2'h1;
    localparam logic [1:0] SPD_8  = 2'h2;
    localparam logic [1:0] SPD_4  = 2'h3;
    localparam logic [6:0] DIV_64 = 7'h40;
    localparam logic [6:0] DIV_16 = 7'h10;
    localparam logic [6:0] DIV_8  = 7'h08;
    localparam logic [6:0] DIV_4  = 7'h04;
    localparam logic [6:0] DIV_SUB = 7'h04;

    // ============================================================
    // Switching delays in machine cycles
    localparam logic [5:0] SW_SUB_CYC = 6'h20;
    localparam logic [5:0] SW_ONE_CYC = 6'h01;

    // ============================================================
    // Bit-access command from the CPU core
    typedef struct packed {
        logic       wr_nib;
        logic       bit_set;
        logic       bit_clr;
        logic       sel_scc;
        logic [1:0] bit_idx;
        logic [3:0] data;
    } ccg_cmd_s;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_HALT = 3'b010,
        ST_STOP = 3'b100
    } ccg_state_e;

endpackage

// *** logic/ccg_divider.sv ***
// Tick divider that gates a clock enable by a selectable ratio
`timescale 1ns/1ns
module ccg_divider #(
    parameter int W = 7
) (
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic         src_tick,
    input  wire logic [W-1:0] ratio,
    output logic              tick
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         tick_r;
    logic         tick_nxt;

    assign tick = tick_r;

    // ============================================================
    // Count source ticks; one output tick per ratio source ticks
    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (src_tick) begin
            if (cnt_r >= ratio - W'(1)) begin
                cnt_nxt  = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + W'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (ce) begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end
endmodule

// *** logic/ccg_top.sv ***
// CPU clock generator control: select registers, standby, clock enables
`timescale 1ns/1ns
module ccg_top (
    core_clk,
    sys_rst,
    ce,
    main_osc_tick_pin,
    sub_osc_tick_pin,
    cmd_valid,
    cmd,
    stop_exec,
    halt_exec,
    standby_release,
    bank_enable_flag,
    cpu_clock_speed_and_standby,
    system_clock_source_select,
    cpu_tick,
    periph_tick,
    watch_tick,
    main_osc_stopped,
    main_osc_input_gnd,
    halt_mode,
    stop_mode,
    switching
);
    input  wire logic            core_clk;
    input  wire logic            sys_rst;
    input  wire logic            ce;
    input  wire logic            main_osc_tick_pin;
    input  wire logic            sub_osc_tick_pin;
    input  wire logic            cmd_valid;
    input  wire ccg_pkg::ccg_cmd_s cmd;
    input  wire logic            stop_exec;
    input  wire logic            halt_exec;
    input  wire logic            standby_release;
    input  wire logic            bank_enable_flag;
    output logic [3:0]           cpu_clock_speed_and_standby;
    output logic [3:0]           system_clock_source_select;
    output logic                 cpu_tick;
    output logic                 periph_tick;
    output logic                 watch_tick;
    output logic                 main_osc_stopped;
    output logic                 main_osc_input_gnd;
    output logic                 halt_mode;
    output logic                 stop_mode;
    output logic                 switching;

    // ============================================================
    // Pin synchronisers and edge detect
    logic [2:0] main_sy_r;
    logic [2:0] sub_sy_r;
    logic       main_edge;
    logic       sub_edge;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            main_sy_r <= 3'h0;
            sub_sy_r  <= 3'h0;
        end else if (ce) begin
            main_sy_r <= {main_sy_r[1:0], main_osc_tick_pin};
            sub_sy_r  <= {sub_sy_r[1:0], sub_osc_tick_pin};
        end
    end

    // Edge looks only at stages two and three, never the first flop
    assign main_edge = main_sy_r[1] & ~main_sy_r[2];
    assign sub_edge  = sub_sy_r[1] & ~sub_sy_r[2];

    // ============================================================
    // Registers and standby state
    logic [3:0]          pcc_r;
    logic [3:0]          pcc_nxt;
    logic [3:0]          scc_r;
    logic [3:0]          scc_nxt;
    ccg_pkg::ccg_state_e st_r;
    ccg_pkg::ccg_state_e st_nxt;
    logic [1:0]          spd_act_r;
    logic [1:0]          spd_act_nxt;
    logic                src_act_r;
    logic                src_act_nxt;
    logic [5:0]          sw_cnt_r;
    logic [5:0]          sw_cnt_nxt;
    logic                main_stopped;
    logic                cyc_tick;

    function automatic logic [6:0] div_of(input logic [1:0] spd);
        case (spd)
            ccg_pkg::SPD_64: div_of = ccg_pkg::DIV_64;
            ccg_pkg::SPD_16: div_of = ccg_pkg::DIV_16;
            ccg_pkg::SPD_8:  div_of = ccg_pkg::DIV_8;
            default:         div_of = ccg_pkg::DIV_4;
        endcase
    endfunction

    always_comb begin
        pcc_nxt     = pcc_r;
        scc_nxt     = scc_r;
        st_nxt      = st_r;
        spd_act_nxt = spd_act_r;
        src_act_nxt = src_act_r;
        sw_cnt_nxt  = sw_cnt_r;
        // Register writes; bank flag not consulted
        if (cmd_valid && cmd.wr_nib && !cmd.sel_scc) begin
            pcc_nxt = {2'b00, cmd.data[ccg_pkg::SPD_HI:ccg_pkg::SPD_LO]};
        end
        if (cmd_valid && cmd.sel_scc && (cmd.bit_set || cmd.bit_clr)) begin
            // One bit per access, so bits 0 and 3 never change together
            if (cmd.bit_idx == 2'(ccg_pkg::SRC_BIT) ||
                cmd.bit_idx == 2'(ccg_pkg::OSCOFF_BIT)) begin
                scc_nxt[cmd.bit_idx] = cmd.bit_set;
            end
        end
        // Standby entry: STOP refused on sub clock
        if (st_r == ccg_pkg::ST_RUN) begin
            if (stop_exec && !src_act_r) begin
                pcc_nxt[ccg_pkg::STOP_BIT] = 1'b1;
                st_nxt = ccg_pkg::ST_STOP;
            end else if (halt_exec) begin
                pcc_nxt[ccg_pkg::HALT_BIT] = 1'b1;
                st_nxt = ccg_pkg::ST_HALT;
            end
        end else if (standby_release) begin
            pcc_nxt[ccg_pkg::STOP_BIT] = 1'b0;
            pcc_nxt[ccg_pkg::HALT_BIT] = 1'b0;
            st_nxt = ccg_pkg::ST_RUN;
        end
        // Old clock kept until delay ends
        if (sw_cnt_r != 6'h00) begin
            if (cyc_tick) begin
                sw_cnt_nxt = sw_cnt_r - 6'h01;
            end
            if (sw_cnt_r == 6'h01 && cyc_tick) begin
                spd_act_nxt = pcc_r[ccg_pkg::SPD_HI:ccg_pkg::SPD_LO];
                src_act_nxt = scc_r[ccg_pkg::SRC_BIT];
            end
        end else if (pcc_r[ccg_pkg::SPD_HI:ccg_pkg::SPD_LO] != spd_act_r ||
                     scc_r[ccg_pkg::SRC_BIT] != src_act_r) begin
            sw_cnt_nxt = (scc_r[ccg_pkg::SRC_BIT] && !src_act_r) ?
                         ccg_pkg::SW_SUB_CYC : ccg_pkg::SW_ONE_CYC;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pcc_r     <= ccg_pkg::REG_RST;
            scc_r     <= ccg_pkg::REG_RST;
            st_r      <= ccg_pkg::ST_RUN;
            spd_act_r <= ccg_pkg::SPD_64;
            src_act_r <= 1'b0;
            sw_cnt_r  <= 6'h00;
        end else if (ce) begin
            pcc_r     <= pcc_nxt;
            scc_r     <= scc_nxt;
            st_r      <= st_nxt;
            spd_act_r <= spd_act_nxt;
            src_act_r <= src_act_nxt;
            sw_cnt_r  <= sw_cnt_nxt;
        end
    end

    // ============================================================
    // Main oscillator stop: bit 3 only on sub clock, or STOP mode
    assign main_stopped = (scc_r[ccg_pkg::OSCOFF_BIT] && src_act_r) ||
                          st_r == ccg_pkg::ST_STOP;

    // ============================================================
    // Clock enables: sub clock ignores speed field
    logic       main_ok;
    logic       cpu_src;
    logic [6:0] cpu_ratio;
    logic       cpu_div_tick;
    logic       per_div_tick;

    assign main_ok   = main_edge && !main_stopped;
    assign cpu_src   = src_act_r ? sub_edge : main_ok;
    assign cpu_ratio = src_act_r ? ccg_pkg::DIV_SUB : div_of(spd_act_r);
    assign cyc_tick  = cpu_div_tick;

    ccg_divider #(.W(7)) u_cpu_div (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .src_tick (cpu_src),
        .ratio    (cpu_ratio),
        .tick     (cpu_div_tick)
    );

    // Peripherals run from main clock / 4; dead once main stops
    ccg_divider #(.W(7)) u_per_div (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .src_tick (main_ok),
        .ratio    (ccg_pkg::DIV_4),
        .tick     (per_div_tick)
    );

    // ============================================================
    // Output registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cpu_tick           <= 1'b0;
            periph_tick        <= 1'b0;
            watch_tick         <= 1'b0;
            main_osc_stopped   <= 1'b0;
            main_osc_input_gnd <= 1'b0;
            halt_mode          <= 1'b0;
            stop_mode          <= 1'b0;
            switching          <= 1'b0;
        end else if (ce) begin
            // CPU frozen in either standby mode
            cpu_tick           <= cpu_div_tick &&
                                  st_r == ccg_pkg::ST_RUN;
            periph_tick        <= per_div_tick;
            watch_tick         <= sub_edge;
            main_osc_stopped   <= main_stopped;
            main_osc_input_gnd <= main_stopped;
            halt_mode          <= st_r == ccg_pkg::ST_HALT;
            stop_mode          <= st_r == ccg_pkg::ST_STOP;
            switching          <= sw_cnt_r != 6'h00;
        end
    end

    assign cpu_clock_speed_and_standby = pcc_r;
    assign system_clock_source_select  = scc_r;

    // bank_enable_flag deliberately unused
    logic unused_bank;
    assign unused_bank = bank_enable_flag;
endmodule

// *** sim/ccg_top_monitor.sv ***
// Assertion checker for the clock generator control block
`timescale 1ns/1ns
module ccg_top_monitor (
    input wire logic              core_clk,
    input wire logic              sys_rst,
    input wire logic              ce,
    input wire logic              cmd_valid,
    input wire ccg_pkg::ccg_cmd_s cmd,
    input wire logic              stop_exec,
    input wire logic              halt_exec,
    input wire logic              standby_release,
    input wire logic [3:0]        cpu_clock_speed_and_standby,
    input wire logic [3:0]        system_clock_source_select,
    input wire logic              cpu_tick,
    input wire logic              periph_tick,
    input wire logic              main_osc_stopped,
    input wire logic              halt_mode,
    input wire logic              stop_mode,
    input wire logic              switching
);
    wire logic [3:0] pc   = cpu_clock_speed_and_standby;
    wire logic [3:0] sc   = system_clock_source_select;
    wire logic       idle = ce && pc[3:2] == 2'h0;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ============================================================
    // Standby entry steps
    // Source must be steady for two edges: the switch flag lags the write
    sequence s_stop_req;
        idle && stop_exec && sc == 4'h0 && !switching &&
        $past(sc) == 4'h0 && $past(sc, 2) == 4'h0;
    endsequence
    sequence s_in_stop;
        pc[3] ##1 stop_mode;
    endsequence
    sequence s_in_halt;
        pc[2] ##1 halt_mode;
    endsequence
    // ============================================================
    // Properties
    AST_RESET_ZERO: assert property (
        $fell(sys_rst) && $past(ce) |-> pc == 4'h0 && sc == 4'h0)
        else $error("reset left a register set");
    AST_NIB_WRITE: assert property (
        idle && cmd_valid && cmd.wr_nib && !cmd.sel_scc && !stop_exec &&
        !halt_exec |=> pc == {2'h0, $past(cmd.data[1:0])})
        else $error("bad nib write");
    AST_STOP_ENTRY: assert property (s_stop_req |=> s_in_stop)
        else $error("stop not entered");
    AST_HALT_ENTRY: assert property (
        idle && halt_exec && !stop_exec && !cmd_valid |=> s_in_halt)
        else $error("halt missed");
    AST_STOP_ON_SUB: assert property (
        ce && stop_exec && sc[0] && $past(sc[0], 2) && !switching
        |=> !pc[3]) else $error("stop taken on sub clock");
    AST_RELEASE: assert property (
        ce && standby_release && pc[3:2] != 2'h0 |=> pc[3:2] == 2'h0)
        else $error("no release");
    AST_QUIET: assert property (
        halt_mode || stop_mode |-> !cpu_tick)
        else $error("cpu tick in standby");
    AST_PERIPH_STOP: assert property (
        main_osc_stopped [*2] |-> !periph_tick)
        else $error("peripheral tick with main stopped");
endmodule
bind ccg_top ccg_top_monitor u_mon (.core_clk, .sys_rst, .ce, .cmd_valid,
    .cmd, .stop_exec, .halt_exec, .standby_release, .cpu_tick, .periph_tick,
    .cpu_clock_speed_and_standby, .system_clock_source_select,
    .main_osc_stopped, .halt_mode, .stop_mode, .switching);

// *** sim/ccg_top_tb.sv ***
// Testbench for the clock generator control block
`timescale 1ns/1ns
module ccg_top_tb;
    logic              core_clk, sys_rst, ce, main_osc_tick_pin;
    logic              sub_osc_tick_pin, cmd_valid, stop_exec, halt_exec;
    logic              standby_release, bank_enable_flag, cpu_tick;
    logic              periph_tick, watch_tick, main_osc_stopped, gnd;
    logic              halt_mode, stop_mode, switching;
    logic [3:0]        pc, sc;
    ccg_pkg::ccg_cmd_s cmd;
    int                n_fail, checks_done, cyc, p;
    int                dv[4] = '{64, 16, 8, 4};
    ccg_top dut (.core_clk, .sys_rst, .ce, .main_osc_tick_pin,
        .sub_osc_tick_pin, .cmd_valid, .cmd, .stop_exec, .halt_exec,
        .standby_release, .bank_enable_flag, .cpu_tick, .periph_tick,
        .cpu_clock_speed_and_standby(pc), .system_clock_source_select(sc),
        .watch_tick, .main_osc_stopped, .main_osc_input_gnd(gnd),
        .halt_mode, .stop_mode, .switching);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ============================================================
    // Main tick every 2 cycles, sub tick every 16; hang guard
    always @(negedge core_clk) begin
        cyc <= cyc + 1;
        main_osc_tick_pin <= ~main_osc_tick_pin;
        if (cyc % 8 == 0) sub_osc_tick_pin <= ~sub_osc_tick_pin;
        if (cyc > 60000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(logic [3:0] op, logic [1:0] ix, logic [3:0] d);
        @(negedge core_clk);
        cmd = {op, ix, d};
        cmd_valid = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
    endtask
    task automatic pulse(logic [2:0] v);
        @(negedge core_clk);
        {stop_exec, halt_exec, standby_release} = v;
        @(negedge core_clk);
        {stop_exec, halt_exec, standby_release} = 3'h0;
    endtask
    function automatic logic tk(int s);
        return s == 0 ? cpu_tick : s == 1 ? periph_tick : watch_tick;
    endfunction
    // Second pass measures; the first only aligns to a tick
    task automatic period(int s, output int per);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do @(negedge core_clk); while (tk(s) !== 1'b1 && ++n < 3000);
        end
        per = n < 3000 ? n + 1 : 0;
    endtask
    task automatic settle();
        for (int k = 0; k < 6000 && (k < 4 || switching !== 1'b0); k++)
            @(negedge core_clk);
    endtask
    initial begin
        {n_fail, checks_done, cyc} = '0;
        {sys_rst, ce, main_osc_tick_pin, sub_osc_tick_pin} = 4'hc;
        {cmd_valid, stop_exec, halt_exec, standby_release} = 4'h0;
        bank_enable_flag = 1'b0;
        cmd = '0;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        check("speed reg", 8'h00, pc);
        check("source reg", 8'h00, sc);
        // Oscillator model stands at the standard rate, so code 11 is legal
        for (int i = 3; i >= 0; i--) begin
            send(4'h8, 2'h0, {2'h3, i[1:0]});
            check("speed reg", {6'h0, i[1:0]}, pc);
            // Delay counter loads one edge late, its flag one edge later
            repeat (2) @(negedge core_clk);
            check("switching", 8'h01, switching);
            settle();
            period(0, p);
            check("cpu period", 8'(dv[i] * 2), 8'(p));
        end
        ce = 1'b0;
        send(4'h8, 2'h0, 4'h3);
        check("frozen reg", 8'h00, pc);
        ce = 1'b1;
        // Main oscillator model is a crystal, so STOP is allowed
        pulse(3'h4);
        check("stop bit", 8'h08, pc);
        @(negedge core_clk);
        check("stop mode", 8'h01, stop_mode);
        pulse(3'h1);
        check("released", 8'h00, pc);
        bank_enable_flag = 1'b1;
        pulse(3'h2);
        check("halt bit", 8'h04, pc);
        period(0, p);
        check("halt cpu period", 8'h00, 8'(p));
        period(1, p);
        check("periph period", 8'h08, 8'(p));
        pulse(3'h1);
        check("released", 8'h00, pc);
        send(4'h8, 2'h0, 4'h3);
        send(4'h5, 2'h0, 4'h0);
        check("source reg", 8'h01, sc);
        settle();
        period(0, p);
        check("sub cpu period", 8'h40, 8'(p));
        send(4'h8, 2'h0, 4'h2);
        settle();
        period(0, p);
        check("sub cpu period", 8'h40, 8'(p));
        pulse(3'h4);
        check("stop on sub", 8'h02, pc);
        pulse(3'h2);
        check("halt on sub", 8'h06, pc);
        pulse(3'h1);
        send(4'h5, 2'h1, 4'h0);
        check("source bit 1", 8'h01, sc);
        send(4'h5, 2'h3, 4'h0);
        repeat (3) @(negedge core_clk);
        check("main stopped", 8'h01, main_osc_stopped);
        check("input grounded", 8'h01, gnd);
        period(1, p);
        check("periph period", 8'h00, 8'(p));
        period(2, p);
        check("watch period", 8'h10, 8'(p));
        send(4'h3, 2'h3, 4'h0);
        send(4'h3, 2'h0, 4'h0);
        check("source reg", 8'h00, sc);
        settle();
        period(0, p);
        check("main cpu period", 8'h10, 8'(p));
        // Second reset in mid-run with both registers non-zero
        send(4'h5, 2'h0, 4'h0);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        check("reset speed", 8'h00, pc);
        check("reset source", 8'h00, sc);
        complete_run();
    end
endmodule
